/* File: logic/ext_clock_sync.sv */
// External count-clock pin sampler and edge detector
module ext_clock_sync
(
    // Clock and reset
    input  wire logic                              clock,
    input  wire logic                              rst,
    // Pin and selection
    input  wire logic                              pinLevel,
    input  wire timer_prescaler_pkg::clock_select_t clockSelect,
    // Count pulse
    output logic                                   countPulse
);

    logic latchStage;
    logic syncStage;
    logic lastStage;
    logic next_countPulse;
    logic pinMode;

    // ********************************************************
    // Sampling: latch open while clock high, then flops
    // ********************************************************
    // Latch modelled as a negedge flop: holds the value seen at end of high phase
    always_ff @(negedge clock or posedge rst)
    begin
        if (rst)
            latchStage <= 1'b0;
        else
            latchStage <= pinLevel;
    end

    // ********************************************************
    // Edge detector
    // ********************************************************
    always_comb
    begin
        pinMode = (clockSelect == timer_prescaler_pkg::CLK_PIN_FALL) ||
                  (clockSelect == timer_prescaler_pkg::CLK_PIN_RISE);
        next_countPulse = 1'b0;
        // Pin direction is ignored, so software can toggle it to count
        if (pinMode)
        begin
            if (clockSelect == timer_prescaler_pkg::CLK_PIN_RISE)
                next_countPulse = syncStage && !lastStage;
            else
                next_countPulse = !syncStage && lastStage;
        end
    end

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            syncStage  <= 1'b0;
            lastStage  <= 1'b0;
        end
        else
        begin
            syncStage  <= latchStage;
            lastStage  <= syncStage;
        end
    end

    // Left unregistered: the parent's tick flop makes edge to count 2.5 to 3.5 cycles
    assign countPulse = next_countPulse;

endmodule

/* File: logic/timer_prescaler_capture_flags.sv */
// Timer interrupt flags/enables, capture latch with shared high byte, shared prescaler
module timer_prescaler_capture_flags
(
    // Clock and reset
    input  wire logic                               clock,
    input  wire logic                               rst,
    // Core register port
    input  wire timer_prescaler_pkg::bus_req_t      busReq,
    output logic [7:0]                              busRdata,
    input  wire logic                               globalIrqEnable,
    input  wire timer_prescaler_pkg::vector_ack_t   vectorAck,
    output timer_prescaler_pkg::vector_ack_t        irqRequest,
    // Timer datapath side
    input  wire logic [15:0]                        wideCounterValue,
    input  wire logic [3:0]                         waveformModeField,
    input  wire timer_prescaler_pkg::clock_select_t wideClockSelect,
    input  wire timer_prescaler_pkg::clock_select_t narrowClockSelect,
    input  wire timer_prescaler_pkg::timer_events_t timerEvents,
    input  wire logic                               comparatorEvent,
    input  wire logic                               captureFromComparator,
    input  wire logic                               captureRiseEdge,
    output logic                                    wideCountTick,
    output logic                                    narrowCountTick,
    output logic [7:0]                              sharedHighByte,
    // Pins
    input  wire logic                               captureEventPin,
    input  wire logic                               wideExtClockPin,
    input  wire logic                               narrowExtClockPin
);

    // ********************************************************
    // State
    // ********************************************************
    localparam int PRESCALER_W = timer_prescaler_pkg::PRESCALER_WIDTH;

    logic [7:0]  flagReg;
    logic [7:0]  enableReg;
    logic        syncHold;
    logic        prescalerReset;
    logic [PRESCALER_W-1:0] prescaler;
    logic [15:0] captureValue;
    logic [7:0]  highLatch;
    logic [1:0]  capSync;
    logic        capLast;

    logic [7:0]  next_flagReg;
    logic [7:0]  next_enableReg;
    logic        next_syncHold;
    logic        next_prescalerReset;
    logic [PRESCALER_W-1:0] next_prescaler;
    logic [15:0] next_captureValue;
    logic [7:0]  next_highLatch;
    logic [7:0]  next_busRdata;
    logic        next_capLast;
    logic        captureEvent;
    logic        captureIsTop;
    logic [7:0]  setMask;
    logic [7:0]  clearMask;
    logic [7:0]  ackMask;
    logic        wideTickRaw;
    logic        narrowTickRaw;
    logic        widePinPulse;
    logic        narrowPinPulse;
    logic [PRESCALER_W:0] tapPulse;
    // Registered below so each request leaves a flop
    timer_prescaler_pkg::vector_ack_t next_irqRequest;


    // Tick for one clock select, given prescaler tap pulses and pin pulse
    function automatic logic select_tick
    (
        input timer_prescaler_pkg::clock_select_t sel,
        input logic [PRESCALER_W:0]               taps,
        input logic                               pinPulse
    );
        logic t;
        t = 1'b0;
        case (sel)
            timer_prescaler_pkg::CLK_STOP:     t = 1'b0;
            timer_prescaler_pkg::CLK_DIRECT:   t = 1'b1;
            timer_prescaler_pkg::CLK_DIV8:     t = taps[timer_prescaler_pkg::TAP_DIV8];
            timer_prescaler_pkg::CLK_DIV64:    t = taps[timer_prescaler_pkg::TAP_DIV64];
            timer_prescaler_pkg::CLK_DIV256:   t = taps[timer_prescaler_pkg::TAP_DIV256];
            timer_prescaler_pkg::CLK_DIV1024:  t = taps[timer_prescaler_pkg::TAP_DIV1024];
            default:                           t = pinPulse;
        endcase
        return t;
    endfunction

    // ********************************************************
    // External clock pins
    // ********************************************************
    ext_clock_sync wideSync
    (
        .clock       (clock),
        .rst         (rst),
        .pinLevel    (wideExtClockPin),
        .clockSelect (wideClockSelect),
        .countPulse  (widePinPulse)
    );

    ext_clock_sync narrowSync
    (
        .clock       (clock),
        .rst         (rst),
        .pinLevel    (narrowExtClockPin),
        .clockSelect (narrowClockSelect),
        .countPulse  (narrowPinPulse)
    );

    // ********************************************************
    // Prescaler and count ticks
    // ********************************************************
    always_comb
    begin
        // Free running, never gated by the selects
        next_prescaler = prescaler + 1'b1;
        if (prescalerReset)
            next_prescaler = '0;
        // Tap k pulses once every 2**k clocks, when the low k bits wrap
        // Ripple and-chain keeps every bit select constant
        tapPulse[0] = !prescalerReset;
        for (int k = 1; k <= PRESCALER_W; k++)
            tapPulse[k] = tapPulse[k-1] && prescaler[k-1];
        wideTickRaw   = select_tick(wideClockSelect, tapPulse, widePinPulse);
        narrowTickRaw = select_tick(narrowClockSelect, tapPulse, narrowPinPulse);
    end

    // ********************************************************
    // Register file, flags, capture
    // ********************************************************
    always_comb
    begin
        captureIsTop = (waveformModeField == timer_prescaler_pkg::WGM_PFC_CAP) ||
                       (waveformModeField == timer_prescaler_pkg::WGM_PC_CAP) ||
                       (waveformModeField == timer_prescaler_pkg::WGM_CTC_CAP) ||
                       (waveformModeField == timer_prescaler_pkg::WGM_FAST_CAP);
        // Capture pin disconnected while capture register is TOP
        captureEvent = !captureIsTop &&
                       (captureFromComparator ? comparatorEvent :
                        (captureRiseEdge ? (capSync[1] && !capLast)
                                         : (!capSync[1] && capLast)));
        next_capLast = capSync[1];

        setMask = '0;
        // Events arrive already tied to the timer clock; forced strobes never drive them
        setMask[timer_prescaler_pkg::WIDE_OVF_BIT]     = timerEvents.wideOverflow;
        setMask[timer_prescaler_pkg::FL_WIDE_CMP_B]    = timerEvents.wideCmpB;
        setMask[timer_prescaler_pkg::FL_WIDE_CMP_A]    = timerEvents.wideCmpA;
        setMask[timer_prescaler_pkg::CAPTURE_BIT]      =
            captureIsTop ? timerEvents.wideTop : captureEvent;
        setMask[timer_prescaler_pkg::NARROW_CMP_B_BIT] = timerEvents.narrowCmpB;
        setMask[timer_prescaler_pkg::NARROW_OVF_BIT]   = timerEvents.narrowOverflow;
        setMask[timer_prescaler_pkg::NARROW_CMP_A_BIT] = timerEvents.narrowCmpA;

        ackMask = '0;
        ackMask[timer_prescaler_pkg::WIDE_OVF_BIT]     = vectorAck.wideOverflow;
        ackMask[timer_prescaler_pkg::FL_WIDE_CMP_B]    = vectorAck.wideCmpB;
        ackMask[timer_prescaler_pkg::FL_WIDE_CMP_A]    = vectorAck.wideCmpA;
        ackMask[timer_prescaler_pkg::CAPTURE_BIT]      = vectorAck.capture;
        ackMask[timer_prescaler_pkg::NARROW_CMP_B_BIT] = vectorAck.narrowCmpB;
        ackMask[timer_prescaler_pkg::NARROW_OVF_BIT]   = vectorAck.narrowOverflow;
        ackMask[timer_prescaler_pkg::NARROW_CMP_A_BIT] = vectorAck.narrowCmpA;

        clearMask = ackMask;
        if (busReq.write && busReq.addr == timer_prescaler_pkg::FLAG_REG_ADDR)
            clearMask = clearMask | busReq.wdata;

        next_flagReg = (flagReg & ~clearMask) | setMask;
        next_flagReg[timer_prescaler_pkg::RESERVED_BIT] = 1'b0;

        next_enableReg = enableReg;
        if (busReq.write && busReq.addr == timer_prescaler_pkg::ENABLE_REG_ADDR)
        begin
            next_enableReg = busReq.wdata;
            next_enableReg[timer_prescaler_pkg::RESERVED_BIT] = 1'b0;
        end

        next_syncHold = syncHold;
        // Reset bit self-clears one cycle after being written unless held
        next_prescalerReset = prescalerReset && syncHold;
        if (busReq.write && busReq.addr == timer_prescaler_pkg::SYNC_REG_ADDR)
        begin
            next_syncHold = busReq.wdata[timer_prescaler_pkg::SYNC_HOLD_BIT];
            // Sync bit decides whether the written reset bit is held; dropping it from one forces the reset bit low
            next_prescalerReset = busReq.wdata[timer_prescaler_pkg::PRESCALE_RST_BIT];
            // Writing one resets now; dropping sync mode releases it
            if (!busReq.wdata[timer_prescaler_pkg::SYNC_HOLD_BIT] && syncHold)
                next_prescalerReset = 1'b0;
        end

        next_captureValue = captureValue;
        if (captureEvent)
            next_captureValue = wideCounterValue;

        // Low-byte read loads the latch; high-byte write loads it too
        next_highLatch = highLatch;
        if (busReq.read && busReq.addr == timer_prescaler_pkg::CAPTURE_LO_ADDR)
            next_highLatch = captureValue[15:8];
        if (busReq.write && busReq.addr == timer_prescaler_pkg::CAPTURE_HI_ADDR)
            next_highLatch = busReq.wdata;

        next_busRdata = busRdata;
        if (busReq.read)
        begin
            case (busReq.addr)
                timer_prescaler_pkg::FLAG_REG_ADDR:   next_busRdata = flagReg;
                timer_prescaler_pkg::ENABLE_REG_ADDR: next_busRdata = enableReg;
                timer_prescaler_pkg::SYNC_REG_ADDR:
                    next_busRdata = {syncHold, 6'h00, prescalerReset};
                timer_prescaler_pkg::CAPTURE_LO_ADDR: next_busRdata = captureValue[7:0];
                timer_prescaler_pkg::CAPTURE_HI_ADDR: next_busRdata = highLatch;
                default:                              next_busRdata = 8'h00;
            endcase
        end

        next_irqRequest.wideOverflow   = globalIrqEnable &&
            enableReg[timer_prescaler_pkg::WIDE_OVF_BIT] &&
            flagReg[timer_prescaler_pkg::WIDE_OVF_BIT];
        next_irqRequest.wideCmpA       = globalIrqEnable &&
            enableReg[timer_prescaler_pkg::EN_WIDE_CMP_A] &&
            flagReg[timer_prescaler_pkg::FL_WIDE_CMP_A];
        next_irqRequest.wideCmpB       = globalIrqEnable &&
            enableReg[timer_prescaler_pkg::EN_WIDE_CMP_B] &&
            flagReg[timer_prescaler_pkg::FL_WIDE_CMP_B];
        next_irqRequest.capture        = globalIrqEnable &&
            enableReg[timer_prescaler_pkg::CAPTURE_BIT] &&
            flagReg[timer_prescaler_pkg::CAPTURE_BIT];
        next_irqRequest.narrowOverflow = globalIrqEnable &&
            enableReg[timer_prescaler_pkg::NARROW_OVF_BIT] &&
            flagReg[timer_prescaler_pkg::NARROW_OVF_BIT];
        next_irqRequest.narrowCmpA     = globalIrqEnable &&
            enableReg[timer_prescaler_pkg::NARROW_CMP_A_BIT] &&
            flagReg[timer_prescaler_pkg::NARROW_CMP_A_BIT];
        next_irqRequest.narrowCmpB     = globalIrqEnable &&
            enableReg[timer_prescaler_pkg::NARROW_CMP_B_BIT] &&
            flagReg[timer_prescaler_pkg::NARROW_CMP_B_BIT];
    end

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            flagReg         <= timer_prescaler_pkg::FLAG_RESET;
            enableReg       <= timer_prescaler_pkg::ENABLE_RESET;
            syncHold        <= 1'b0;
            prescalerReset  <= 1'b0;
            prescaler       <= '0;
            captureValue    <= 16'h0000;
            highLatch       <= 8'h00;
            capSync         <= 2'h0;
            capLast         <= 1'b0;
            busRdata        <= 8'h00;
            irqRequest      <= '0;
            wideCountTick   <= 1'b0;
            narrowCountTick <= 1'b0;
        end
        else
        begin
            flagReg         <= next_flagReg;
            enableReg       <= next_enableReg;
            syncHold        <= next_syncHold;
            prescalerReset  <= next_prescalerReset;
            prescaler       <= next_prescaler;
            captureValue    <= next_captureValue;
            highLatch       <= next_highLatch;
            capSync         <= {capSync[0], captureEventPin};
            capLast         <= next_capLast;
            busRdata        <= next_busRdata;
            irqRequest      <= next_irqRequest;
            wideCountTick   <= wideTickRaw;
            narrowCountTick <= narrowTickRaw;
        end
    end

    assign sharedHighByte = highLatch;

endmodule

/* File: logic/timer_prescaler_pkg.sv */
// Package: register map, field positions and carrier types for the timer flag/prescaler block
package timer_prescaler_pkg;

    // ********************************************************
    // Register offsets (I/O space)
    // ********************************************************
    localparam logic [7:0] FLAG_REG_ADDR    = 8'h39;
    localparam logic [7:0] ENABLE_REG_ADDR  = 8'h3a;
    localparam logic [7:0] SYNC_REG_ADDR    = 8'h67;
    localparam logic [7:0] CAPTURE_LO_ADDR  = 8'h86;
    localparam logic [7:0] CAPTURE_HI_ADDR  = 8'h87;

    // ********************************************************
    // Reset values
    // ********************************************************
    localparam logic [7:0] FLAG_RESET       = 8'h00;
    localparam logic [7:0] ENABLE_RESET     = 8'h00;
    localparam logic [7:0] SYNC_RESET       = 8'h00;

    // ********************************************************
    // Field positions
    // ********************************************************
    localparam int WIDE_OVF_BIT     = 7;
    localparam int EN_WIDE_CMP_A    = 6;
    localparam int EN_WIDE_CMP_B    = 5;
    localparam int FL_WIDE_CMP_B    = 6;
    localparam int FL_WIDE_CMP_A    = 5;
    localparam int RESERVED_BIT     = 4;
    localparam int CAPTURE_BIT      = 3;
    localparam int NARROW_CMP_B_BIT = 2;
    localparam int NARROW_OVF_BIT   = 1;
    localparam int NARROW_CMP_A_BIT = 0;
    localparam int SYNC_HOLD_BIT    = 7;
    localparam int PRESCALE_RST_BIT = 0;

    // ********************************************************
    // Prescaler taps and clock select codes
    // ********************************************************
    localparam int PRESCALER_WIDTH  = 10;
    localparam int TAP_DIV8         = 3;
    localparam int TAP_DIV64        = 6;
    localparam int TAP_DIV256       = 8;
    localparam int TAP_DIV1024      = 10;

    typedef enum logic [2:0]
    {
        CLK_STOP     = 3'h0,
        CLK_DIRECT   = 3'h1,
        CLK_DIV8     = 3'h2,
        CLK_DIV64    = 3'h3,
        CLK_DIV256   = 3'h4,
        CLK_DIV1024  = 3'h5,
        CLK_PIN_FALL = 3'h6,
        CLK_PIN_RISE = 3'h7
    } clock_select_t;

    // Waveform modes that use the capture register as TOP
    localparam logic [3:0] WGM_PFC_CAP  = 4'h8;
    localparam logic [3:0] WGM_PC_CAP   = 4'ha;
    localparam logic [3:0] WGM_CTC_CAP  = 4'hc;
    localparam logic [3:0] WGM_FAST_CAP = 4'he;

    // ********************************************************
    // Carriers
    // ********************************************************
    typedef struct packed
    {
        logic       write;
        logic       read;
        logic [7:0] addr;
        logic [7:0] wdata;
    } bus_req_t;

    typedef struct packed
    {
        logic wideOverflow;
        logic wideCmpA;
        logic wideCmpB;
        logic wideTop;
        logic narrowOverflow;
        logic narrowCmpA;
        logic narrowCmpB;
    } timer_events_t;

    typedef struct packed
    {
        logic wideOverflow;
        logic wideCmpA;
        logic wideCmpB;
        logic capture;
        logic narrowOverflow;
        logic narrowCmpA;
        logic narrowCmpB;
    } vector_ack_t;

endpackage

/* File: verif/core_bus_model.sv */
// Processor core stand-in: register accesses and vector acknowledges
module core_bus_model
(
    // Clock
    input wire logic                         clock,
    // Register port
    output timer_prescaler_pkg::bus_req_t    busReq,
    input wire logic [7:0]                   busRdata,
    output logic                             globalIrqEnable,
    output timer_prescaler_pkg::vector_ack_t vectorAck
);
    timeunit 1ns;
    timeprecision 1ps;
    initial
    begin
        busReq = '0;
        globalIrqEnable = 1'b0;
        vectorAck = '0;
    end
    // One-cycle strobe; data is picked up after the edge that registers it
    task automatic access(input logic wr, input logic [7:0] addr, input logic [7:0] wdata,
                          output logic [7:0] rdata);
        @(posedge clock);
        busReq <= {wr, !wr, addr, wdata};
        @(posedge clock);
        busReq <= '0;
        #1 rdata = busRdata;
    endtask
    task automatic ack(input logic [6:0] v);
        @(posedge clock);
        vectorAck <= v;
        @(posedge clock);
        vectorAck <= '0;
    endtask
endmodule

/* File: verif/timer_prescaler_capture_flags_asserts.sv */
// Port-level checks for the timer flag, capture and prescaler block
module timer_prescaler_capture_flags_asserts
(
    // Clock and reset
    input wire logic                               clock,
    input wire logic                               rst,
    // Watched ports
    input wire timer_prescaler_pkg::bus_req_t      busReq,
    input wire logic [7:0]                         busRdata,
    input wire logic                               globalIrqEnable,
    input wire timer_prescaler_pkg::vector_ack_t   irqRequest,
    input wire timer_prescaler_pkg::clock_select_t wideClockSelect,
    input wire logic                               wideCountTick,
    input wire logic [7:0]                         sharedHighByte,
    input wire logic                               wideExtClockPin
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (rst);
    irq_needs_global_a: assert property (irqRequest != '0 |-> $past(globalIrqEnable))
        else $error("irq request without global enable");
    reserved_zero_a: assert property (busReq.read && busReq.addr inside {8'h39, 8'h3a}
        |=> busRdata[4] == 1'b0) else $error("reserved bit read as one");
    high_byte_read_a: assert property (busReq.read && busReq.addr == 8'h87
        |=> busRdata == $past(sharedHighByte)) else $error("high byte not from latch");
    stop_no_tick_a: assert property (wideClockSelect == timer_prescaler_pkg::CLK_STOP [*2]
        |-> !wideCountTick) else $error("tick while stopped");
    div8_gap_a: assert property (wideCountTick && wideClockSelect == timer_prescaler_pkg::CLK_DIV8
        |=> (!wideCountTick || wideClockSelect != timer_prescaler_pkg::CLK_DIV8) [*7])
        else $error("divide by eight tick too early");
    pin_rise_tick_a: assert property ($rose(wideExtClockPin)
        && wideClockSelect == timer_prescaler_pkg::CLK_PIN_RISE |-> ##[1:4] wideCountTick)
        else $error("pin edge gave no tick");
    pin_fall_quiet_a: assert property ((wideExtClockPin
        && wideClockSelect == timer_prescaler_pkg::CLK_PIN_FALL) [*5] |-> !wideCountTick)
        else $error("tick without falling edge");
    rdata_hold_a: assert property (!busReq.read |=> $stable(busRdata))
        else $error("read data changed without read");
endmodule

/* File: verif/timer_prescaler_capture_flags_tb.sv */
// Self-checking bench for the timer flag, capture and prescaler block
module timer_prescaler_capture_flags_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic                               clock = 1'b0;
    logic                               rst = 1'b1;
    logic [15:0]                        counter = '0;
    logic                               cmpEv = 1'b0;
    logic                               pin = 1'b0;
    logic                               capPin = 1'b0;
    logic                               capSrc = 1'b1;
    logic [3:0]                         wgm = 4'h0;
    int                                 nTicks = 0;
    int                                 n0;
    logic [7:0]                         rd, lo, en, m, fl;
    logic [6:0]                         v;
    timer_prescaler_pkg::clock_select_t sel = timer_prescaler_pkg::CLK_STOP;
    timer_prescaler_pkg::timer_events_t ev = '0;
    timer_prescaler_pkg::bus_req_t      busReq;
    timer_prescaler_pkg::vector_ack_t   ack, irq;
    logic [7:0]                         busRdata, hiByte;
    logic                               gie, tick, nTick;
    int                                 error_cnt = 0;
    int                                 compares = 0;
    int                                 ticks = 0;
    int                                 t0;
    int                                 divs [5] = '{1, 8, 64, 256, 1024};
    logic [7:0]                         addrs [4] = '{8'h39, 8'h3a, 8'h67, 8'h55};
    core_bus_model core (.clock(clock), .busReq(busReq), .busRdata(busRdata),
        .globalIrqEnable(gie), .vectorAck(ack));
    timer_prescaler_capture_flags dut (.clock(clock), .rst(rst), .busReq(busReq),
        .busRdata(busRdata), .globalIrqEnable(gie), .vectorAck(ack), .irqRequest(irq),
        .wideCounterValue(counter), .waveformModeField(wgm), .wideClockSelect(sel),
        .narrowClockSelect(sel), .timerEvents(ev), .comparatorEvent(cmpEv),
        .captureFromComparator(capSrc), .captureRiseEdge(1'b1), .wideCountTick(tick),
        .narrowCountTick(nTick), .sharedHighByte(hiByte), .captureEventPin(capPin),
        .wideExtClockPin(pin), .narrowExtClockPin(1'b0));
    // Flag bit positions differ from the event order; top events ignored outside capture-TOP
    function automatic logic [7:0] toFlags(logic [6:0] s, logic cap);
        return {s[6], s[4], s[5], 1'b0, s[3] & cap, s[0], s[2], s[1]};
    endfunction
    task automatic check(string name, logic [15:0] exp, logic [15:0] got);
        compares++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic results();
        if (error_cnt == 0 && compares > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    initial
    begin
        forever #5 clock = ~clock;
    end
    // Counting on the falling edge keeps snapshots free of races
    always @(negedge clock) ticks += int'(tick === 1'b1);
    always @(negedge clock) nTicks += int'(nTick === 1'b1);
    initial
    begin
        repeat (20000) @(posedge clock);
        error_cnt++;
        results();
    end
    initial
    begin
        void'($urandom(32'h0619));
        repeat (6) @(posedge clock);
        rst <= 1'b0;
        fl = 8'h00;
        foreach (addrs[i])
        begin
            core.access(1'b0, addrs[i], 8'h00, rd);
            check("reset value", 16'h0000, rd);
        end
        en = 8'($urandom);
        core.access(1'b1, 8'h3a, en, rd);
        core.access(1'b0, 8'h3a, 8'h00, rd);
        check("enables", en & 8'hef, rd);
        repeat (8)
        begin
            v = 7'($urandom);
            m = 8'($urandom);
            fork
                core.access(1'b1, 8'h39, m, lo);
                begin
                    @(posedge clock);
                    ev <= v;
                    wgm <= 4'($urandom) & 4'hc;
                    core.globalIrqEnable <= 1'($urandom);
                    @(posedge clock);
                    ev <= '0;
                end
            join
            fl = (fl & ~m) | toFlags(v, wgm[3]);
            core.access(1'b0, 8'h39, 8'h00, rd);
            check("flags", fl, rd);
            check("irq", {7{gie}} & {fl[7] & en[7], fl[5] & en[6], fl[6] & en[5],
                fl[3] & en[3], fl[1] & en[1], fl[0] & en[0], fl[2] & en[2]}, irq);
            v = 7'($urandom);
            core.ack(v);
            fl &= ~toFlags(v, 1'b1);
            core.access(1'b0, 8'h39, 8'h00, rd);
            check("flags after ack", fl, rd);
        end
        @(posedge clock);
        counter <= 16'($urandom);
        cmpEv <= 1'b1;
        wgm <= 4'h0;
        @(posedge clock);
        cmpEv <= 1'b0;
        fl[3] = 1'b1;
        core.access(1'b0, 8'h86, 8'h00, lo);
        core.access(1'b0, 8'h87, 8'h00, rd);
        check("capture", counter, {rd, lo});
        core.access(1'b0, 8'h39, 8'h00, rd);
        check("capture flag", fl, rd);
        @(posedge clock);
        capSrc <= 1'b0;
        capPin <= 1'b1;
        counter <= 16'($urandom);
        repeat (4) @(posedge clock);
        core.access(1'b0, 8'h86, 8'h00, lo);
        core.access(1'b0, 8'h87, 8'h00, rd);
        check("pin capture", counter, {rd, lo});
        core.access(1'b1, 8'h67, 8'h01, rd);
        core.access(1'b0, 8'h67, 8'h00, rd);
        check("prescaler reset", 8'h00, rd);
        @(posedge clock);
        sel <= timer_prescaler_pkg::CLK_DIV8;
        core.access(1'b1, 8'h67, 8'h81, rd);
        core.access(1'b0, 8'h67, 8'h00, rd);
        t0 = ticks;
        repeat (24) @(posedge clock);
        check("sync hold", 16'h8100, {rd, 8'(ticks - t0)});
        sel <= timer_prescaler_pkg::CLK_STOP;
        core.access(1'b1, 8'h67, 8'h00, rd);
        core.access(1'b0, 8'h67, 8'h00, rd);
        check("sync release", 8'h00, rd);
        for (int i = 1; i < 8; i++)
        begin
            @(posedge clock);
            sel <= timer_prescaler_pkg::clock_select_t'(i);
            repeat (i > 5 ? 4 : 1) @(posedge clock);
            t0 = ticks;
            n0 = nTicks;
            if (i < 6)
                repeat (2 * divs[i - 1]) @(posedge clock);
            else
            begin
                repeat (8)
                begin
                    pin <= ~pin;
                    repeat (5 - 2 * pin) @(posedge clock);
                end
                repeat (6) @(posedge clock);
            end
            check("tick count", i < 6 ? 2 : 4, ticks - t0);
            check("narrow tick count", i < 6 ? 2 : 0, nTicks - n0);
            sel <= timer_prescaler_pkg::CLK_STOP;
            repeat (2) @(posedge clock);
        end
        results();
    end
endmodule
bind timer_prescaler_capture_flags timer_prescaler_capture_flags_asserts chk (.clock(clock),
    .rst(rst), .busReq(busReq), .busRdata(busRdata), .globalIrqEnable(globalIrqEnable),
    .irqRequest(irqRequest), .wideClockSelect(wideClockSelect), .wideCountTick(wideCountTick),
    .sharedHighByte(sharedHighByte), .wideExtClockPin(wideExtClockPin));
